// File: logic/shp_device.sv
// Purpose: Device end of the parallel host port with local memory
// Assumes: All pins are asynchronous and pass two flip-flops first
// Notes: Memory stands for control registers, connection and data memories
// Summary of operation
// R1 - Direct bus: low pins are address 0-2
// R2 - 16x8 mode: low pins become serial 8-10
// R3 - Direct bus: next pins are address 3-5
// R4 - 16x8 mode: upper pins become serial 11-13
// R5 - Direct or DS mux: strobe high enables transfer
// R6 - Separate-strobe mux: low read strobe drives data
// R7 - Direction pin selects read or write
// R8 - Separate-strobe mux: low write strobe takes data
// R9 - Chip select low required; else ignored
// R10 - Data bus reaches registers and memories
// R11 - Mux: address taken from data lines first
// R12 - Mux: address sampled on strobe falling edge
// R13 - Style input high selects multiplexed bus
// R14 - Acknowledge pulled low when transfer completes
// R15 - Drive data only during selected read
`timescale 1ns/1ps
module shp_device (
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_sep_strobes,
	input  wire logic       i_cfg_16x8,
	shp_if.device           bus,
	output logic [2:0]      o_extra_serial_inputs_lo,
	output logic [2:0]      o_extra_serial_inputs_hi,
	output logic            o_busy
);
	logic [7:0]             mem [shp_pkg::MEM_DEPTH];
	logic [7:0]             next_mem_word;
	logic                   mem_we;
	logic [18:0]            s1;
	logic [18:0]            s2;
	logic [18:0]            pin_raw;
	logic                   sync_cs_n;
	logic                   sync_ds;
	logic                   sync_dir;
	logic                   sync_als;
	logic                   sync_mux;
	logic [5:0]             sync_addr;
	logic [7:0]             sync_data;
	logic                   als_d;
	logic                   next_als_d;
	logic [5:0]             addr_latch;
	logic [5:0]             next_addr_latch;
	logic [5:0]             acc_addr;
	logic                   rd_req;
	logic                   wr_req;
	logic                   sel_read;
	shp_pkg::shp_state_t    state;
	shp_pkg::shp_state_t    next_state;
	logic [1:0]             ack_cnt;
	logic [1:0]             next_ack_cnt;
	logic [7:0]             rd_data;
	logic [7:0]             next_rd_data;
	logic                   drive;
	logic                   next_drive;
	logic [2:0]             ser_lo;
	logic [2:0]             ser_hi;
	logic [2:0]             next_ser_lo;
	logic [2:0]             next_ser_hi;

	// All pins pass the same two stages, so strobes and data stay aligned
	assign pin_raw = {bus.cs_n, bus.data_strobe, bus.dir_wr, bus.addr_latch_strobe,
		bus.bus_style_select, bus.addr_pins, bus.host_data_lines};
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1 <= shp_pkg::SYNC_RESET;
			s2 <= shp_pkg::SYNC_RESET;
		end else begin
			s1 <= pin_raw;
			s2 <= s1;
		end
	end
	assign sync_cs_n = s2[18];
	assign sync_ds   = s2[17];
	assign sync_dir  = s2[16];
	assign sync_als  = s2[15];
	assign sync_mux  = s2[14];                                         // R13
	assign sync_addr = s2[13:8];
	assign sync_data = s2[7:0];

	// Style decode: separate strobes only apply to the multiplexed bus
	always_comb begin
		rd_req = 1'b0;
		wr_req = 1'b0;
		if (!sync_cs_n) begin                                          // R9
			if (sync_mux && i_sep_strobes) begin
				rd_req = !sync_ds;                                     // R6
				wr_req = !sync_dir && sync_ds;                         // R8
			end else if (sync_ds) begin                                // R5
				rd_req = sync_dir;                                     // R7
				wr_req = !sync_dir;                                    // R7
			end
		end
	end

	// Address comes from the latch in mux mode, from pins otherwise
	always_comb begin
		next_als_d = sync_als;
		next_addr_latch = addr_latch;
		if (sync_mux && als_d && !sync_als) begin                      // R12
			next_addr_latch = sync_data[5:0];                          // R11
		end
		acc_addr = sync_mux ? addr_latch : sync_addr;                  // R1 R3
	end

	always_comb begin
		next_state = state;
		next_ack_cnt = ack_cnt;
		next_rd_data = rd_data;
		next_drive = 1'b0;
		mem_we = 1'b0;
		next_mem_word = sync_data;
		sel_read = rd_req && (state != shp_pkg::SHP_DONE || ack_cnt != shp_pkg::ACK_ZERO);
		case (state)
			shp_pkg::SHP_IDLE: begin
				if (rd_req || wr_req) begin
					next_state = shp_pkg::SHP_ACTIVE;
				end
			end
			shp_pkg::SHP_ACTIVE: begin
				if (!(rd_req || wr_req)) begin
					next_state = shp_pkg::SHP_IDLE;
				end else begin
					mem_we = wr_req;                                   // R10
					next_rd_data = mem[acc_addr];                      // R10
					next_ack_cnt = shp_pkg::ACK_CYCLES;
					next_state = shp_pkg::SHP_DONE;
				end
			end
			shp_pkg::SHP_DONE: begin
				if (ack_cnt != shp_pkg::ACK_ZERO) begin
					next_ack_cnt = ack_cnt - 2'h1;
				end
				if (!(rd_req || wr_req)) begin
					next_ack_cnt = shp_pkg::ACK_ZERO;
					next_state = shp_pkg::SHP_IDLE;
				end
			end
			default: begin
				next_state = shp_pkg::SHP_IDLE;
			end
		endcase
		next_drive = rd_req && (state == shp_pkg::SHP_DONE);           // R15
	end

	// Serial inputs share the address pins; zero when not in 16x8
	always_comb begin
		next_ser_lo = 3'h0;
		next_ser_hi = 3'h0;
		if (i_cfg_16x8) begin
			next_ser_lo = sync_addr[2:0];                              // R2
			next_ser_hi = sync_addr[5:3];                              // R4
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= shp_pkg::SHP_IDLE;
			ack_cnt <= shp_pkg::ACK_ZERO;
			rd_data <= shp_pkg::DATA_RESET;
			drive <= 1'b0;
			als_d <= 1'b0;
			addr_latch <= shp_pkg::ADDR_RESET;
			ser_lo <= 3'h0;
			ser_hi <= 3'h0;
		end else begin
			state <= next_state;
			ack_cnt <= next_ack_cnt;
			rd_data <= next_rd_data;
			drive <= next_drive;
			als_d <= next_als_d;
			addr_latch <= next_addr_latch;
			ser_lo <= next_ser_lo;
			ser_hi <= next_ser_hi;
		end
	end

	// Memory is cleared to MEM_RESET on every reset, not only at power-up
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < shp_pkg::MEM_DEPTH; i++) begin
				mem[i] <= shp_pkg::MEM_RESET;
			end
		end else if (mem_we) begin
			mem[acc_addr] <= next_mem_word;                            // R10
		end
	end

	assign bus.host_data_lines_d    = rd_data;
	assign bus.host_data_lines_d_oe = drive && rd_req;                 // R6 R15
	assign bus.transfer_ack_n_oe    = (state == shp_pkg::SHP_DONE);    // R14
	assign o_extra_serial_inputs_lo = ser_lo;
	assign o_extra_serial_inputs_hi = ser_hi;
	assign o_busy = (state != shp_pkg::SHP_IDLE) || sel_read;
endmodule // shp_device

// File: logic/shp_pkg.sv
// Purpose: Shared constants and types for the switch host port
// Assumes: Single clock i_mclk at 40 MHz, active-low async reset
// Notes: Bus style and strobe meanings are selected per access
package shp_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int SER_W  = 3;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [5:0] ADDR_RESET = 6'h00;
	// Pin stages reset to idle levels; latch strobe low so no false falling edge
	localparam logic [18:0] SYNC_RESET = 19'h73FFF;
	// Cycles a held read keeps sel_read high once a transfer completes
	localparam logic [1:0] ACK_CYCLES = 2'h2;
	localparam logic [1:0] ACK_ZERO   = 2'h0;
	// Number of host memory words visible through the six-bit address
	localparam int MEM_DEPTH = 64;
	localparam logic [7:0] MEM_RESET  = 8'h00;
	// Cycles the host counts down in each address and latch phase before the data phase
	localparam logic [2:0] HOLD_CYCLES = 3'h6;
	localparam logic [2:0] HOLD_ZERO   = 3'h0;

	typedef enum logic [1:0] {
		SHP_BUS_DIRECT  = 2'h0,
		SHP_BUS_MUX_DS  = 2'h1,
		SHP_BUS_MUX_RW  = 2'h3
	} shp_style_t;

	typedef enum logic [1:0] {
		SHP_IDLE   = 2'h0,
		SHP_ACTIVE = 2'h1,
		SHP_DONE   = 2'h3
	} shp_state_t;

	typedef enum logic [2:0] {
		SHP_H_IDLE = 3'h0,
		SHP_H_ADDR = 3'h1,
		SHP_H_LAT  = 3'h3,
		SHP_H_DATA = 3'h2,
		SHP_H_WAIT = 3'h6,
		SHP_H_END  = 3'h7
	} shp_hstate_t;
endpackage

// File: logic/shp_if.sv
// Purpose: Pin-level carrier between the host and the switch port
// Assumes: Data lines and acknowledge resolved here from enables
// Notes: Acknowledge is open drain with a pull-up
`timescale 1ns/1ps
interface shp_if;
	logic       bus_style_select;
	logic       cs_n;
	logic       data_strobe;
	logic       dir_wr;
	logic       addr_latch_strobe;
	logic [5:0] addr_pins;
	logic [7:0] host_data_lines_h;
	logic       host_data_lines_h_oe;
	logic [7:0] host_data_lines_d;
	logic       host_data_lines_d_oe;
	logic [7:0] host_data_lines;
	logic       transfer_ack_n_oe;
	logic       transfer_ack_n;

	assign host_data_lines = host_data_lines_d_oe ? host_data_lines_d :
		(host_data_lines_h_oe ? host_data_lines_h : 8'hFF);
	assign transfer_ack_n = transfer_ack_n_oe ? 1'b0 : 1'b1;

	modport device (
		input  bus_style_select, cs_n, data_strobe, dir_wr, addr_latch_strobe, addr_pins,
		input  host_data_lines,
		output host_data_lines_d, host_data_lines_d_oe, transfer_ack_n_oe
	);
	modport host (
		output bus_style_select, cs_n, data_strobe, dir_wr, addr_latch_strobe, addr_pins,
		output host_data_lines_h, host_data_lines_h_oe,
		input  host_data_lines, transfer_ack_n
	);
endinterface

// File: logic/shp_host.sv
// Purpose: Host end driving the parallel port from a simple request
// Assumes: Device acknowledges each transfer while strobe is held
// Notes: One access at a time; request taken only when ready
`timescale 1ns/1ps
module shp_host (
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_mux,
	input  wire logic       i_sep_strobes,
	input  wire logic       i_req,
	input  wire logic       i_write,
	input  wire logic [5:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic            o_ready,
	output logic            o_done,
	output logic [7:0]      o_rdata,
	shp_if.host             bus
);
	shp_pkg::shp_hstate_t   state;
	shp_pkg::shp_hstate_t   next_state;
	logic                   wr;
	logic                   next_wr;
	logic [5:0]             addr;
	logic [5:0]             next_addr;
	logic [7:0]             wdata;
	logic [7:0]             next_wdata;
	logic [7:0]             rdata;
	logic [7:0]             next_rdata;
	logic                   done;
	logic                   next_done;
	logic [2:0]             cnt;
	logic [2:0]             next_cnt;
	logic                   ack_s1;
	logic                   ack_s2;
	logic                   sep;

	// Acknowledge comes from outside logic; two stages before use
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ack_s1 <= 1'b1;
			ack_s2 <= 1'b1;
		end else begin
			ack_s1 <= bus.transfer_ack_n;
			ack_s2 <= ack_s1;
		end
	end

	assign sep = i_mux && i_sep_strobes;

	always_comb begin
		next_state = state;
		next_wr = wr;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		next_done = 1'b0;
		next_cnt = cnt;
		case (state)
			shp_pkg::SHP_H_IDLE: begin
				if (i_req) begin
					next_wr = i_write;
					next_addr = i_addr;
					next_wdata = i_wdata;
					next_cnt = shp_pkg::HOLD_CYCLES;
					next_state = i_mux ? shp_pkg::SHP_H_ADDR : shp_pkg::SHP_H_DATA;
				end
			end
			shp_pkg::SHP_H_ADDR: begin
				if (cnt == shp_pkg::HOLD_ZERO) begin
					next_cnt = shp_pkg::HOLD_CYCLES;
					next_state = shp_pkg::SHP_H_LAT;
				end else begin
					next_cnt = cnt - 3'h1;
				end
			end
			shp_pkg::SHP_H_LAT: begin
				if (cnt == shp_pkg::HOLD_ZERO) begin
					next_cnt = shp_pkg::HOLD_CYCLES;
					next_state = shp_pkg::SHP_H_DATA;
				end else begin
					next_cnt = cnt - 3'h1;
				end
			end
			shp_pkg::SHP_H_DATA: begin
				if (!ack_s2) begin
					next_rdata = bus.host_data_lines;
					next_state = shp_pkg::SHP_H_WAIT;
				end
			end
			shp_pkg::SHP_H_WAIT: begin
				if (ack_s2) begin
					next_done = 1'b1;
					next_state = shp_pkg::SHP_H_END;
				end
			end
			shp_pkg::SHP_H_END: begin
				next_state = shp_pkg::SHP_H_IDLE;
			end
			default: begin
				next_state = shp_pkg::SHP_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= shp_pkg::SHP_H_IDLE;
			wr <= 1'b0;
			addr <= shp_pkg::ADDR_RESET;
			wdata <= shp_pkg::DATA_RESET;
			rdata <= shp_pkg::DATA_RESET;
			done <= 1'b0;
			cnt <= shp_pkg::HOLD_ZERO;
		end else begin
			state <= next_state;
			wr <= next_wr;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
			done <= next_done;
			cnt <= next_cnt;
		end
	end

	// Pins are decoded from the state so each phase is clean
	// Strobes drop once the acknowledge is seen; the device holds it until then
	logic in_data;
	assign in_data = (state == shp_pkg::SHP_H_DATA);
	assign bus.bus_style_select = i_mux;                               // R13
	assign bus.cs_n = !(in_data || state == shp_pkg::SHP_H_ADDR
		|| state == shp_pkg::SHP_H_LAT);                               // R9
	assign bus.addr_latch_strobe = (state == shp_pkg::SHP_H_ADDR);     // R12
	assign bus.addr_pins = i_mux ? 6'h00 : addr;                       // R1 R3
	// Strobe meanings differ with the separate-strobe style
	assign bus.data_strobe = sep ? !(in_data && !wr) : in_data;        // R5 R6
	assign bus.dir_wr = sep ? !(in_data && wr) : !wr;                  // R7 R8
	assign bus.host_data_lines_h = (state == shp_pkg::SHP_H_ADDR ||
		state == shp_pkg::SHP_H_LAT) ? {2'h0, addr} : wdata;           // R11
	assign bus.host_data_lines_h_oe = (i_mux && (state == shp_pkg::SHP_H_ADDR ||
		state == shp_pkg::SHP_H_LAT)) || (in_data && wr);
	assign o_ready = (state == shp_pkg::SHP_H_IDLE);
	assign o_done = done;
	assign o_rdata = rdata;
endmodule // shp_host

// File: verif/shp_assertions.sv
// Purpose: Concurrent checks on the wires between host and device
// Assumes: One clock, active-low reset, device inputs pass two sync flops
// Notes: Bounds leave slack for that sync lag rather than exact cycles
`timescale 1ns/1ps
module shp_assertions (
	input wire logic       i_mclk,
	input wire logic       i_resetn,
	input wire logic       i_sep_strobes,
	input wire logic       i_cfg_16x8,
	input wire logic       bus_style_select,
	input wire logic       cs_n,
	input wire logic       data_strobe,
	input wire logic       dir_wr,
	input wire logic       addr_latch_strobe,
	input wire logic [5:0] addr_pins,
	input wire logic       host_data_lines_h_oe,
	input wire logic       host_data_lines_d_oe,
	input wire logic       transfer_ack_n,
	input wire logic [2:0] o_extra_serial_inputs_lo,
	input wire logic [2:0] o_extra_serial_inputs_hi
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	wire logic sep = bus_style_select && i_sep_strobes;

	chk_idle_no_drive: assert property (cs_n [*4] |-> !host_data_lines_d_oe)
		else $error("data lines driven without chip select");
	chk_drive_on_read: assert property ($rose(host_data_lines_d_oe) |->
		!cs_n && (sep ? !data_strobe : (dir_wr && data_strobe)))
		else $error("data drive started outside a read");
	chk_write_no_drive: assert property ((!cs_n && !dir_wr) [*4] |-> !host_data_lines_d_oe)
		else $error("data lines driven during a write");
	chk_no_contention: assert property (!(host_data_lines_d_oe && host_data_lines_h_oe))
		else $error("both ends drive the data lines");
	chk_ack_comes: assert property ($fell(cs_n) |-> ##[1:40] !transfer_ack_n)
		else $error("no acknowledge for a selected access");
	chk_ack_release: assert property ($rose(cs_n) |-> ##[1:4] transfer_ack_n)
		else $error("acknowledge held after deselect");
	chk_ack_needs_cs: assert property (cs_n [*6] |-> transfer_ack_n)
		else $error("acknowledge without chip select");
	chk_latch_addr: assert property ($fell(addr_latch_strobe) && bus_style_select |->
		$past(host_data_lines_h_oe))
		else $error("address not on data lines at latch edge");
	chk_addr_steady: assert property (!bus_style_select && !cs_n && !$past(cs_n) |->
		$stable(addr_pins))
		else $error("address pins moved during a direct access");
	chk_serial_low: assert property ((i_cfg_16x8 && $stable(addr_pins)) [*5] |->
		o_extra_serial_inputs_lo == addr_pins[2:0])
		else $error("low serial inputs do not follow pins");
	chk_serial_high: assert property ((i_cfg_16x8 && $stable(addr_pins)) [*5] |->
		o_extra_serial_inputs_hi == addr_pins[5:3])
		else $error("high serial inputs do not follow pins");
endmodule // shp_assertions

// File: verif/test_switch_cpu_host_port.sv
// Purpose: Random and corner accesses in all three bus styles
// Assumes: Host and device share clock and reset
// Notes: A bench copy of the memory gives the expected read data
`timescale 1ns/1ps
module test_switch_cpu_host_port;
	logic       mclk = 1'b0;
	logic       resetn = 1'b0;
	logic       mux = 1'b0;
	logic       sep = 1'b0;
	logic       cfg = 1'b0;
	logic       req = 1'b0;
	logic       wr = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00;
	logic       ready;
	logic       done;
	logic       busy;
	logic [7:0] rdata;
	logic [2:0] ser_lo;
	logic [2:0] ser_hi;
	logic [7:0] mem [64];
	logic [7:0] got;
	logic [5:0] sa;
	int         n_errors = 0;
	int         n_tests = 0;
	int         seed;

	always #12.5 mclk = ~mclk;
	shp_if bus_if ();
	shp_device shp_device_inst (.i_mclk(mclk), .i_resetn(resetn), .i_sep_strobes(sep),
		.i_cfg_16x8(cfg), .bus(bus_if.device), .o_extra_serial_inputs_lo(ser_lo),
		.o_extra_serial_inputs_hi(ser_hi), .o_busy(busy));
	shp_host shp_host_inst (.i_mclk(mclk), .i_resetn(resetn), .i_mux(mux), .i_sep_strobes(sep),
		.i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_ready(ready),
		.o_done(done), .o_rdata(rdata), .bus(bus_if.host));
	shp_assertions shp_assertions_inst (.i_mclk(mclk), .i_resetn(resetn),
		.i_sep_strobes(sep), .i_cfg_16x8(cfg), .bus_style_select(bus_if.bus_style_select),
		.cs_n(bus_if.cs_n), .data_strobe(bus_if.data_strobe), .dir_wr(bus_if.dir_wr),
		.addr_latch_strobe(bus_if.addr_latch_strobe), .addr_pins(bus_if.addr_pins),
		.host_data_lines_h_oe(bus_if.host_data_lines_h_oe),
		.host_data_lines_d_oe(bus_if.host_data_lines_d_oe),
		.transfer_ack_n(bus_if.transfer_ack_n), .o_extra_serial_inputs_lo(ser_lo),
		.o_extra_serial_inputs_hi(ser_hi));

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [7:0] expect_read(input logic [5:0] a);
		return mem[a];
	endfunction

	// Random idle gap first, so back-to-back and spaced accesses both occur
	task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
		int k;
		k = 0;
		repeat ($urandom_range(0, 2)) @(posedge mclk);
		while (ready !== 1'b1 && k < 100) begin
			@(negedge mclk);
			k++;
		end
		@(posedge mclk);
		req <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		req <= 1'b0;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (done !== 1'b1 && k < 400);
		check8("done flag", 8'h01, {7'h00, done});
		check8("busy after access", 8'h00, {7'h00, busy});
		got = rdata;
		if (w)
			mem[a] = d;
	endtask

	task automatic run_style(input string name, input logic m, input logic s);
		logic [5:0] al [8];
		@(posedge mclk);
		mux <= m;
		sep <= s;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			al[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
			access(1'b1, al[i], (i == 2) ? 8'hFF : 8'($urandom));
		end
		for (int i = 0; i < 8; i++) begin
			access(1'b0, al[i], 8'h00);
			check8("read data", expect_read(al[i]), got);
		end
		$display("test %s done", name);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		seed = $urandom(17806);
		foreach (mem[i]) mem[i] = shp_pkg::MEM_RESET;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		check8("ready after reset", 8'h01, {7'h00, ready});
		check8("ack after reset", 8'h01, {7'h00, bus_if.transfer_ack_n});
		check8("rdata after reset", 8'h00, rdata);
		$display("test reset done");
		run_style("direct", 1'b0, 1'b0);
		run_style("mux_strobe", 1'b1, 1'b0);
		run_style("mux_split", 1'b1, 1'b1);
		@(posedge mclk);
		mux <= 1'b0;
		sep <= 1'b0;
		cfg <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			sa = (i == 0) ? 6'h2A : 6'($urandom);
			access(1'b0, sa, 8'h00);
			check8("read data", expect_read(sa), got);
			repeat (5) @(negedge mclk);
			check8("serial inputs", {2'h0, sa}, {2'h0, ser_hi, ser_lo});
		end
		@(posedge mclk);
		cfg <= 1'b0;
		repeat (6) @(negedge mclk);
		check8("serial outputs off", 8'h00, {2'h0, ser_hi, ser_lo});
		$display("test serial done");
		results();
	end

	// Whole run needs about 1300 cycles; over twenty times that means a hang
	initial begin
		repeat (30000) @(posedge mclk);
		n_errors++;
		results();
	end
endmodule // test_switch_cpu_host_port
